// *** common/ckfo_cfg.svh ***
// Constants of the clock fan-out enable controller
// Summary of operation
// - One reference clock fans out to eighteen outputs in five groups.
// - Standard-mode link up to 100 kbit/s; device is a slave receiver only.
// - Device answers slave address 1101001 in bits 7..1; bit 0 is direction.
// - Three 8-bit registers hold one enable bit per output.
// - Registers are write-only, written in sequence; no random addressing.
// - Every enable bit, reserved included, resets to one.
// - Enable low drives output low; enable high makes output follow clock.
// - Output-enable pin low puts all eighteen outputs in high impedance.
// - Output-enable pin high makes every output operational.
// - First register: bits 0..3 byte-0 outputs, bits 4..7 byte-1 outputs.
// - Second register: bits 0..3 byte-2 outputs, bits 4..7 byte-3 outputs.
// - Third register: bits 6,7 feedback; bits 0..5 reserved, reset to one.
`ifndef CKFO_CFG_SVH
`define CKFO_CFG_SVH

`define CKFO_SLAVE_ADDR  7'h69
`define CKFO_EN_RST      8'hFF
`define CKFO_NUM_REGS    2'h3
`define CKFO_BYTE_BITS   4'h8
`define CKFO_NUM_OUTS    18
`define CKFO_FB_LSB      6
`define CKFO_SYS_CLK_HZ  20000000
`define CKFO_LINK_BPS    100000
`define CKFO_MIN_OVERSMP 8

`endif

// *** common/ckfo_pkg.sv ***
// Types of the clock fan-out enable controller
`default_nettype none

package ckfo_pkg;

  typedef enum logic [2:0] {
    CKFO_IDLE,
    CKFO_ADDR,
    CKFO_ACK_ADDR,
    CKFO_DATA,
    CKFO_ACK_DATA,
    CKFO_IGNORE
  } ckfo_state_t;

  typedef struct packed {
    ckfo_state_t st;
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic        scl_f;
    logic        sda_f;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [1:0]  ptr;
    logic        sda_oe;
    logic        sda_o;
    logic [7:0]  en0;
    logic [7:0]  en1;
    logic [7:0]  en2;
    logic        seen;
  } ckfo_top_st_t;

endpackage

`default_nettype wire

// *** hdl/ckfo_gate.sv ***
// Output gating on the reference clock domain
`include "ckfo_cfg.svh"
`default_nettype none

module ckfo_gate #(
  parameter int N_OUTS = `CKFO_NUM_OUTS
) (
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic [N_OUTS-1:0] en_in,
  input  wire logic              oe_pin,
  output logic      [N_OUTS-1:0] clk_out,
  output logic      [N_OUTS-1:0] out_oe
);

  typedef struct packed {
    logic [N_OUTS-1:0] en_s1;
    logic [N_OUTS-1:0] en_s2;
    logic [N_OUTS-1:0] en_s3;
    logic [N_OUTS-1:0] en_q;
    logic [2:0]        oe_sy;
    logic [N_OUTS-1:0] oe_q;
  } ckfo_gate_st_t;

  ckfo_gate_st_t q;
  ckfo_gate_st_t d;

  if (N_OUTS < 1) begin : g_chk
    $error("ckfo_gate needs at least one output");
  end

  ////////////////////////////////////////////////////////////////////////////
  // All flops on the falling edge, so enables change only while the
  // clock is low and a gated output never shows a cut pulse.
  always_comb begin
    d = q;
    d.en_s1 = en_in;
    d.en_s2 = q.en_s1;
    d.en_s3 = q.en_s2;
    // Whole word waits for two equal samples: no half-old, half-new mix
    if (q.en_s2 == q.en_s3) begin
      d.en_q = q.en_s3;
    end
    d.oe_sy = {q.oe_sy[1:0], oe_pin};
    if (q.oe_sy[1] == q.oe_sy[2]) begin
      d.oe_q = {N_OUTS{q.oe_sy[2]}};
    end
  end

  always_ff @(negedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q.en_s1 <= {N_OUTS{1'b1}};
      q.en_s2 <= {N_OUTS{1'b1}};
      q.en_s3 <= {N_OUTS{1'b1}};
      q.en_q  <= {N_OUTS{1'b1}};
      q.oe_sy <= 3'h7;
      q.oe_q  <= {N_OUTS{1'b1}};
    end else begin
      q <= d;
    end
  end

  assign clk_out = {N_OUTS{ref_clk}} & q.en_q;
  assign out_oe  = q.oe_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(negedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  property p_oe_low_tristates;
    (q.oe_sy[1] == q.oe_sy[2]) && !q.oe_sy[2] |=> out_oe == '0;
  endproperty
  a_oe_low_tristates: assert property (p_oe_low_tristates)
    else $error("outputs still driven after enable pin went low");

  property p_oe_high_drives;
    (q.oe_sy[1] == q.oe_sy[2]) && q.oe_sy[2] |=> out_oe == '1;
  endproperty
  a_oe_high_drives: assert property (p_oe_high_drives)
    else $error("outputs not driven after enable pin went high");

  property p_enable_follows;
    $stable(en_in) ##1 $stable(en_in) |=> ##1 q.en_q == $past(en_in, 4);
  endproperty
  a_enable_follows: assert property (p_enable_follows)
    else $error("gate enable does not follow register enable");

endmodule

`default_nettype wire

// *** hdl/ckfo_top.sv ***
// Serial-controlled 1-to-18 clock fan-out enable controller
`include "ckfo_cfg.svh"
`default_nettype none

module ckfo_top (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       ref_clk,
  input  wire logic       out_enable_pin,
  input  wire logic       serial_clock_pin,
  input  wire logic       serial_data_pin_i,
  output logic            serial_data_pin_o,
  output logic            serial_data_pin_oe,
  output logic      [3:0] mem_byte0_clock_outs,
  output logic      [3:0] mem_byte0_clock_oe,
  output logic      [3:0] mem_byte1_clock_outs,
  output logic      [3:0] mem_byte1_clock_oe,
  output logic      [3:0] mem_byte2_clock_outs,
  output logic      [3:0] mem_byte2_clock_oe,
  output logic      [3:0] mem_byte3_clock_outs,
  output logic      [3:0] mem_byte3_clock_oe,
  output logic      [1:0] pll_feedback_outs,
  output logic      [1:0] pll_feedback_oe
);

  localparam int BIT_CYC = `CKFO_SYS_CLK_HZ / `CKFO_LINK_BPS;

  // Oversampling must see every serial clock phase several times
  if (BIT_CYC < `CKFO_MIN_OVERSMP) begin : g_chk
    $error("system clock too slow for the serial link");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Glitch filter: the value changes once the second and third stages agree
  function automatic logic filt(input logic [2:0] sy, input logic cur);
    filt = (sy[1] == sy[2]) ? sy[2] : cur;
  endfunction

  ckfo_pkg::ckfo_top_st_t q;
  ckfo_pkg::ckfo_top_st_t d;

  logic        scl_n;
  logic        sda_n;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic        byte_done;
  logic [17:0] en_vec;
  logic [17:0] gate_out;
  logic [17:0] gate_oe;

  always_comb begin
    scl_n     = filt(q.scl_sy, q.scl_f);
    sda_n     = filt(q.sda_sy, q.sda_f);
    scl_rise  = scl_n & ~q.scl_f;
    scl_fall  = ~scl_n & q.scl_f;
    // Start and stop only while the serial clock stays high
    start_ev  = q.scl_f & scl_n & q.sda_f & ~sda_n;
    stop_ev   = q.scl_f & scl_n & ~q.sda_f & sda_n;
    byte_done = scl_fall && (q.cnt == `CKFO_BYTE_BITS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave receiver
  always_comb begin
    d = q;
    d.scl_sy = {q.scl_sy[1:0], serial_clock_pin};
    d.sda_sy = {q.sda_sy[1:0], serial_data_pin_i};
    d.scl_f  = scl_n;
    d.sda_f  = sda_n;
    d.seen   = 1'b1;
    d.sda_o  = 1'b0;

    if (stop_ev) begin
      d.st     = ckfo_pkg::CKFO_IDLE;
      d.sda_oe = 1'b0;
    end else if (start_ev) begin
      // Repeated start also restarts the register sequence
      d.st     = ckfo_pkg::CKFO_ADDR;
      d.cnt    = 4'h0;
      d.ptr    = 2'h0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        ckfo_pkg::CKFO_IDLE: begin
          d.sda_oe = 1'b0;
        end

        ckfo_pkg::CKFO_ADDR: begin
          if (scl_rise) begin
            d.sh  = {q.sh[6:0], sda_n};
            d.cnt = q.cnt + 4'h1;
          end else if (byte_done) begin
            // Read requests are not answered: receiver only
            if (q.sh == {`CKFO_SLAVE_ADDR, 1'b0}) begin
              d.st     = ckfo_pkg::CKFO_ACK_ADDR;
              d.sda_oe = 1'b1;
            end else begin
              d.st = ckfo_pkg::CKFO_IGNORE;
            end
          end
        end

        ckfo_pkg::CKFO_ACK_ADDR: begin
          if (scl_fall) begin
            d.st     = ckfo_pkg::CKFO_DATA;
            d.sda_oe = 1'b0;
            d.cnt    = 4'h0;
          end
        end

        ckfo_pkg::CKFO_DATA: begin
          if (scl_rise) begin
            d.sh  = {q.sh[6:0], sda_n};
            d.cnt = q.cnt + 4'h1;
          end else if (byte_done) begin
            d.st     = ckfo_pkg::CKFO_ACK_DATA;
            d.sda_oe = 1'b1;
            case (q.ptr)
              2'h0:    d.en0 = q.sh;
              2'h1:    d.en1 = q.sh;
              2'h2:    d.en2 = q.sh;
              default: d.en0 = q.en0;
            endcase
            // Pointer saturates: later bytes are acked and dropped
            if (q.ptr != `CKFO_NUM_REGS) begin
              d.ptr = q.ptr + 2'h1;
            end
          end
        end

        ckfo_pkg::CKFO_ACK_DATA: begin
          if (scl_fall) begin
            d.st     = ckfo_pkg::CKFO_DATA;
            d.sda_oe = 1'b0;
            d.cnt    = 4'h0;
          end
        end

        ckfo_pkg::CKFO_IGNORE: begin
          d.sda_oe = 1'b0;
        end

        default: begin
          d.st     = ckfo_pkg::CKFO_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q.st     <= ckfo_pkg::CKFO_IDLE;
      q.scl_sy <= 3'h7;
      q.sda_sy <= 3'h7;
      q.scl_f  <= 1'b1;
      q.sda_f  <= 1'b1;
      q.cnt    <= 4'h0;
      q.sh     <= 8'h00;
      q.ptr    <= 2'h0;
      q.sda_oe <= 1'b0;
      q.sda_o  <= 1'b0;
      q.en0    <= `CKFO_EN_RST;
      q.en1    <= `CKFO_EN_RST;
      q.en2    <= `CKFO_EN_RST;
      q.seen   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign serial_data_pin_o  = q.sda_o;
  assign serial_data_pin_oe = q.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Enable map onto the eighteen outputs
  // Reserved bits of the third register are stored but steer nothing
  assign en_vec = {q.en2[`CKFO_FB_LSB+1:`CKFO_FB_LSB], q.en1, q.en0};

  // Enable word is resynchronised and filtered inside the gate
  ckfo_gate #(
    .N_OUTS (`CKFO_NUM_OUTS)
  ) u_gate (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .en_in   (en_vec),
    .oe_pin  (out_enable_pin),
    .clk_out (gate_out),
    .out_oe  (gate_oe)
  );

  assign mem_byte0_clock_outs = gate_out[3:0];
  assign mem_byte1_clock_outs = gate_out[7:4];
  assign mem_byte2_clock_outs = gate_out[11:8];
  assign mem_byte3_clock_outs = gate_out[15:12];
  assign pll_feedback_outs    = gate_out[17:16];
  assign mem_byte0_clock_oe   = gate_oe[3:0];
  assign mem_byte1_clock_oe   = gate_oe[7:4];
  assign mem_byte2_clock_oe   = gate_oe[11:8];
  assign mem_byte3_clock_oe   = gate_oe[15:12];
  assign pll_feedback_oe      = gate_oe[17:16];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  property p_addr_ack;
    q.st == ckfo_pkg::CKFO_ADDR && byte_done && !stop_ev && !start_ev &&
      q.sh == {`CKFO_SLAVE_ADDR, 1'b0}
      |=> q.st == ckfo_pkg::CKFO_ACK_ADDR && serial_data_pin_oe
          && !serial_data_pin_o;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own write address not acknowledged");

  property p_no_foreign_ack;
    q.st == ckfo_pkg::CKFO_ADDR && byte_done &&
      q.sh != {`CKFO_SLAVE_ADDR, 1'b0}
      |=> !serial_data_pin_oe;
  endproperty
  a_no_foreign_ack: assert property (p_no_foreign_ack)
    else $error("foreign address or read acknowledged");

  property p_drive_only_ack;
    serial_data_pin_oe |-> q.st == ckfo_pkg::CKFO_ACK_ADDR ||
                           q.st == ckfo_pkg::CKFO_ACK_DATA;
  endproperty
  a_drive_only_ack: assert property (p_drive_only_ack)
    else $error("data line driven outside an acknowledge");

  property p_first_byte;
    q.st == ckfo_pkg::CKFO_DATA && byte_done && !stop_ev && !start_ev &&
      q.ptr == 2'h0
      |=> q.en0 == $past(q.sh) && q.ptr == 2'h1;
  endproperty
  a_first_byte: assert property (p_first_byte)
    else $error("first data byte not loaded into first register");

  property p_third_byte;
    q.st == ckfo_pkg::CKFO_DATA && byte_done && !stop_ev && !start_ev &&
      q.ptr == 2'h2
      |=> q.en2 == $past(q.sh) && $stable(q.en0) && $stable(q.en1);
  endproperty
  a_third_byte: assert property (p_third_byte)
    else $error("third data byte not loaded into third register");

  property p_extra_dropped;
    q.st == ckfo_pkg::CKFO_DATA && byte_done && q.ptr == `CKFO_NUM_REGS
      |=> $stable(en_vec) && $stable(q.en2) && serial_data_pin_oe;
  endproperty
  a_extra_dropped: assert property (p_extra_dropped)
    else $error("byte beyond the third changed an enable");

  property p_reset_ones;
    !q.seen |-> q.en0 == `CKFO_EN_RST && q.en1 == `CKFO_EN_RST &&
                q.en2 == `CKFO_EN_RST;
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("enable bits not all one after reset");

  property p_stop_idles;
    stop_ev |=> q.st == ckfo_pkg::CKFO_IDLE ##1 !serial_data_pin_oe;
  endproperty
  a_stop_idles: assert property (p_stop_idles)
    else $error("stop condition did not end the transfer");

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing checks: one load per acked data byte up to the third, nothing loads in between
  // Checks read the filtered strobes, the same view the receiver acts on

  property p_second_byte;
    q.st == ckfo_pkg::CKFO_DATA && byte_done && !stop_ev && !start_ev &&
      q.ptr == 2'h1
      |=> q.en1 == $past(q.sh) && $stable(q.en0) && $stable(q.en2) &&
          q.ptr == 2'h2;
  endproperty
  a_second_byte: assert property (p_second_byte)
    else $error("second data byte not loaded into second register");

  property p_data_ack;
    q.st == ckfo_pkg::CKFO_DATA && byte_done
      |=> q.st == ckfo_pkg::CKFO_ACK_DATA && serial_data_pin_oe;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data byte not acknowledged");

  property p_ack_release;
    (q.st == ckfo_pkg::CKFO_ACK_ADDR || q.st == ckfo_pkg::CKFO_ACK_DATA) &&
      scl_fall
      |=> q.st == ckfo_pkg::CKFO_DATA && !serial_data_pin_oe &&
          q.cnt == 4'h0;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("data line not released after the acknowledge clock");

  property p_start_restarts;
    start_ev |=> q.st == ckfo_pkg::CKFO_ADDR && q.ptr == 2'h0 &&
                 q.cnt == 4'h0;
  endproperty
  a_start_restarts: assert property (p_start_restarts)
    else $error("start condition did not restart the register sequence");

  property p_read_refused;
    q.st == ckfo_pkg::CKFO_ADDR && byte_done && q.sh[0]
      |=> q.st == ckfo_pkg::CKFO_IGNORE;
  endproperty
  a_read_refused: assert property (p_read_refused)
    else $error("read request not ignored");

  property p_ignore_holds;
    q.st == ckfo_pkg::CKFO_IGNORE && !start_ev && !stop_ev
      |=> q.st == ckfo_pkg::CKFO_IGNORE && !serial_data_pin_oe;
  endproperty
  a_ignore_holds: assert property (p_ignore_holds)
    else $error("ignored transfer left its wait state");

  // A stop or start in mid-byte must leave the registers alone,
  // so a cut transfer never writes half a byte
  property p_enables_hold;
    !(q.st == ckfo_pkg::CKFO_DATA && byte_done)
      |=> $stable(q.en0) && $stable(q.en1) && $stable(q.en2);
  endproperty
  a_enables_hold: assert property (p_enables_hold)
    else $error("enable register changed outside a byte load");

  property p_bit_count;
    q.cnt <= `CKFO_BYTE_BITS;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("bit counter ran past one byte");

  c_addr_ack: cover property (q.st == ckfo_pkg::CKFO_ACK_ADDR);
  c_third_write: cover property (
    q.st == ckfo_pkg::CKFO_DATA && byte_done && q.ptr == 2'h2);
  c_extra_byte: cover property (
    q.st == ckfo_pkg::CKFO_DATA && byte_done && q.ptr == `CKFO_NUM_REGS);
  c_stop: cover property (stop_ev && q.ptr == `CKFO_NUM_REGS);
  c_restart: cover property (start_ev && q.st == ckfo_pkg::CKFO_DATA);

endmodule

`default_nettype wire

// *** tb/ckfo_i2c_master.sv ***
// Behavioural master on the serial link, timed from the system clock
`default_nettype none

module ckfo_i2c_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quarter bit of 50 cycles gives 100 kbit/s
  localparam int Q = 50;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic qw(input int n);
    repeat (n * Q) @(negedge clk);
  endtask

  // Also serves as repeated start; data is released while clock is low, then pulled low while clock is high
  task automatic start_c();
    sda_pull = 1'b0;
    qw(1);
    scl = 1'b1;
    qw(1);
    sda_pull = 1'b1;
    qw(1);
    scl = 1'b0;
    qw(1);
  endtask

  task automatic stop_c();
    sda_pull = 1'b1;
    qw(1);
    scl = 1'b1;
    qw(1);
    sda_pull = 1'b0;
    qw(2);
  endtask

  // Most significant bit first, then one released bit for the ack
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~b[i];
      qw(1);
      scl = 1'b1;
      qw(2);
      scl = 1'b0;
      qw(1);
    end
    sda_pull = 1'b0;
    qw(1);
    scl = 1'b1;
    qw(1);
    ack = ~sda;
    qw(1);
    scl = 1'b0;
    qw(1);
  endtask
endmodule

`default_nettype wire

// *** tb/ckfo_top_tb_top.sv ***
// Self-checking bench of the clock fan-out enable controller
`default_nettype none

module ckfo_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk = 1'b0;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        out_enable_pin = 1'b1;
  logic        scl;
  logic        sda_pull;
  logic        sd_o;
  logic        sd_oe;
  logic [3:0]  b0, b1, b2, b3, e0, e1, e2, e3;
  logic [1:0]  fb, fe;
  logic [7:0]  bad_addr [3] = '{8'hD3, 8'hD0, 8'h52};
  int          miscompares = 0;
  int          tests_run = 0;
  wire  logic        sda = ~(sda_pull | (sd_oe & ~sd_o));
  wire  logic [17:0] outs = {fb, b3, b2, b1, b0};
  wire  logic [17:0] oes = {fe, e3, e2, e1, e0};

  always #25 sys_clk = ~sys_clk;

  // Reference clock, phase unrelated to the system clock
  initial begin
    #7;
    forever #40 ref_clk = ~ref_clk;
  end

  ckfo_top ckfo_top_i (
    .sys_clk              (sys_clk),
    .arst_n               (arst_n),
    .ref_clk              (ref_clk),
    .out_enable_pin       (out_enable_pin),
    .serial_clock_pin     (scl),
    .serial_data_pin_i    (sda),
    .serial_data_pin_o    (sd_o),
    .serial_data_pin_oe   (sd_oe),
    .mem_byte0_clock_outs (b0),
    .mem_byte0_clock_oe   (e0),
    .mem_byte1_clock_outs (b1),
    .mem_byte1_clock_oe   (e1),
    .mem_byte2_clock_outs (b2),
    .mem_byte2_clock_oe   (e2),
    .mem_byte3_clock_outs (b3),
    .mem_byte3_clock_oe   (e3),
    .pll_feedback_outs    (fb),
    .pll_feedback_oe      (fe)
  );

  ckfo_i2c_master ckfo_i2c_master_i (
    .clk      (sys_clk),
    .sda      (sda),
    .scl      (scl),
    .sda_pull (sda_pull)
  );

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] b, input logic exp_ack);
    logic a;
    ckfo_i2c_master_i.wbyte(b, a);
    check({17'h0, a}, {17'h0, exp_ack});
  endtask

  // Enables cross to the reference clock: let several of its edges pass
  task automatic chk_outs(input logic [17:0] en);
    repeat (8) @(negedge ref_clk);
    @(posedge ref_clk);
    #10;
    check(outs, en);
    check(oes, 18'h3FFFF);
    @(negedge ref_clk);
    #10;
    check(outs, 18'h00000);
  endtask

  initial begin
    #4_000_000;
    miscompares++;
    end_sim();
  end

  initial begin
    repeat (20) @(negedge sys_clk);
    arst_n = 1'b1;
    chk_outs(18'h3FFFF);
    // Wrong address or read direction: no ack, nothing stored
    foreach (bad_addr[i]) begin
      ckfo_i2c_master_i.start_c();
      wr(bad_addr[i], 1'b0);
      wr(8'h00, 1'b0);
      ckfo_i2c_master_i.stop_c();
    end
    chk_outs(18'h3FFFF);
    ckfo_i2c_master_i.start_c();
    wr(8'hD2, 1'b1);
    wr(8'hA5, 1'b1);
    wr(8'h3C, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'h00, 1'b1);
    ckfo_i2c_master_i.stop_c();
    chk_outs({2'h2, 8'h3C, 8'hA5});
    // Repeated start sends the pointer back to the first register
    ckfo_i2c_master_i.start_c();
    wr(8'hD2, 1'b1);
    wr(8'hFF, 1'b1);
    ckfo_i2c_master_i.start_c();
    wr(8'hD2, 1'b1);
    wr(8'h0F, 1'b1);
    ckfo_i2c_master_i.stop_c();
    chk_outs({2'h2, 8'h3C, 8'h0F});
    @(negedge sys_clk);
    out_enable_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    #10;
    check(oes, 18'h00000);
    @(negedge sys_clk);
    out_enable_pin = 1'b1;
    chk_outs({2'h2, 8'h3C, 8'h0F});
    end_sim();
  end
endmodule

`default_nettype wire
